// *** rtl/sfd_cmd_decoder.sv ***
// array command decoder of a serial flash, sampled on the core clock
`include "sfd_map.svh"

//Contract
// - in quad protocol, opcode, address and data move four bits per clock; EDh moves address and data four bits per edge
// - opcode 35h switches to the quad command protocol
// - opcode F5h returns to single-lane command transfer
// - 03h reads without dummy, 0Bh with dummy; data streams until deselect
// - BBh dual address and data, 3Bh dual data; both single-lane mode only
// - EBh quad read in both modes; 6Bh quad data in single-lane mode only
// - 0Dh, BDh, EDh double-rate reads; only EDh also valid in quad mode
// - 02h program in both modes, 38h quad-input single-lane only; 1-256 bytes
// - 20h, 52h, D8h erase 4K, 32K, 64K at the given address
// - 60h or C7h erase whole array, no address, both modes
// - dummy length set by the two dummy select bits
// - address is three bytes, four once long-address mode is on
// - unknown opcode: outputs off, lanes ignored until next select
// - program, erase and protocol switches need deselect on a byte boundary
// - inputs sampled on clock rise, outputs shifted on clock fall; double-rate reads also take address on fall and shift data on rise
module sfd_cmd_decoder #(
  parameter int FIFO_DEPTH = 8
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // flash pins
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // configuration
  input wire logic enter_long_address_cmd,
  input wire logic dummy_count_sel_lo,
  input wire logic dummy_count_sel_hi,
  output logic quad_mode,
  // array read stream
  output logic rd_start,
  output logic [31:0] rd_addr,
  output logic rd_active,
  input wire logic arr_valid,
  output logic arr_ready,
  input wire logic [7:0] arr_data,
  // program data
  output logic prog_byte_valid,
  output logic [7:0] prog_byte,
  // array operation
  output logic op_valid,
  output sfd_pkg::sfd_cmd_kind_t op_kind,
  output logic [31:0] op_addr,
  output logic [8:0] op_bytes
);
  function automatic sfd_pkg::sfd_cmd_info_t cmd_decode(
    input logic [7:0] op,
    input logic quad
  );
    sfd_pkg::sfd_cmd_info_t ci;
    logic spi_only;
    ci = '{sfd_pkg::CK_BAD, 1'b1, `SFD_LANE_1, `SFD_LANE_1, 1'b0, 1'b0};
    spi_only = 1'b0;
    case (op)
      `SFD_OP_READ: begin
        ci.kind = sfd_pkg::CK_READ;
        spi_only = 1'b1;
      end
      `SFD_OP_FAST_READ: begin
        ci.kind = sfd_pkg::CK_READ;
        ci.dummy = 1'b1;
        spi_only = 1'b1;
      end
      `SFD_OP_DUAL_IO_READ: begin
        ci = '{sfd_pkg::CK_READ, 1'b1, `SFD_LANE_2, `SFD_LANE_2, 1'b1, 1'b0};
        spi_only = 1'b1;
      end
      `SFD_OP_DUAL_OUT_READ: begin
        ci = '{sfd_pkg::CK_READ, 1'b1, `SFD_LANE_1, `SFD_LANE_2, 1'b1, 1'b0};
        spi_only = 1'b1;
      end
      `SFD_OP_QUAD_IO_READ: begin
        ci = '{sfd_pkg::CK_READ, 1'b1, `SFD_LANE_4, `SFD_LANE_4, 1'b1, 1'b0};
      end
      `SFD_OP_QUAD_OUT_READ: begin
        ci = '{sfd_pkg::CK_READ, 1'b1, `SFD_LANE_1, `SFD_LANE_4, 1'b1, 1'b0};
        spi_only = 1'b1;
      end
      `SFD_OP_DDR1_READ: begin
        ci = '{sfd_pkg::CK_READ, 1'b1, `SFD_LANE_1, `SFD_LANE_1, 1'b1, 1'b1};
        spi_only = 1'b1;
      end
      `SFD_OP_DDR2_READ: begin
        ci = '{sfd_pkg::CK_READ, 1'b1, `SFD_LANE_2, `SFD_LANE_2, 1'b1, 1'b1};
        spi_only = 1'b1;
      end
      `SFD_OP_DDR4_READ: begin
        ci = '{sfd_pkg::CK_READ, 1'b1, `SFD_LANE_4, `SFD_LANE_4, 1'b1, 1'b1};
      end
      `SFD_OP_PAGE_PROG: ci.kind = sfd_pkg::CK_PROG;
      `SFD_OP_QUAD_PROG: begin
        ci = '{sfd_pkg::CK_PROG, 1'b1, `SFD_LANE_4, `SFD_LANE_4, 1'b0, 1'b0};
        spi_only = 1'b1;
      end
      `SFD_OP_SECTOR_ERASE: ci.kind = sfd_pkg::CK_SE4K;
      `SFD_OP_HALF_BLOCK_ERASE: ci.kind = sfd_pkg::CK_BE32K;
      `SFD_OP_BLOCK_ERASE: ci.kind = sfd_pkg::CK_BE64K;
      `SFD_OP_CHIP_ERASE_A, `SFD_OP_CHIP_ERASE_B: begin
        ci.kind = sfd_pkg::CK_CHIP;
        ci.has_addr = 1'b0;
      end
      `SFD_OP_ENTER_QUAD: begin
        ci.kind = sfd_pkg::CK_ENQ;
        ci.has_addr = 1'b0;
      end
      `SFD_OP_EXIT_QUAD: begin
        ci.kind = sfd_pkg::CK_EXQ;
        ci.has_addr = 1'b0;
      end
      default: ci.kind = sfd_pkg::CK_BAD;
    endcase
    if (quad) begin
      ci.addr_w = `SFD_LANE_4;
      ci.data_w = `SFD_LANE_4;
      if (spi_only) begin
        ci.kind = sfd_pkg::CK_BAD;
      end
    end
    return ci;
  endfunction

  function automatic logic [31:0] shift_in(
    input logic [31:0] s,
    input logic [3:0] io,
    input logic [2:0] w
  );
    case (w)
      `SFD_LANE_1: return {s[30:0], io[0]};
      `SFD_LANE_2: return {s[29:0], io[1:0]};
      default: return {s[27:0], io};
    endcase
  endfunction

  function automatic logic [4:0] dummy_len(input logic [1:0] sel);
    case (sel)
      2'h0: return `SFD_DUMMY_SEL0;
      2'h1: return `SFD_DUMMY_SEL1;
      2'h2: return `SFD_DUMMY_SEL2;
      default: return `SFD_DUMMY_SEL3;
    endcase
  endfunction

  // pin synchronisers: first stage feeds only the second
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic sclk_d_r;
  logic cs_n_d_r;
  sfd_pkg::sfd_state_t state_r;
  sfd_pkg::sfd_state_t state_nxt;
  sfd_pkg::sfd_cmd_info_t info_r;
  logic quad_r;
  logic [31:0] sh_r;
  logic [5:0] phase_cnt_r;
  logic [4:0] dum_cnt_r;
  logic [31:0] addr_r;
  logic [8:0] pcount_r;
  logic [7:0] out_sh_r;
  logic [3:0] out_cnt_r;
  logic fifo_valid;
  logic [7:0] fifo_data;

  wire sclk_s = sync2_r[5];
  wire cs_n_s = sync2_r[4];
  wire [3:0] io_s = sync2_r[3:0];
  wire rise = sclk_s && !sclk_d_r && !cs_n_s;
  wire fall = !sclk_s && sclk_d_r && !cs_n_s;
  wire cs_fall = !cs_n_s && cs_n_d_r;
  wire cs_rise = cs_n_s && !cs_n_d_r;
  wire in_opc = (state_r == sfd_pkg::ST_OPC);
  wire in_addr = (state_r == sfd_pkg::ST_ADDR);
  wire in_rd = (state_r == sfd_pkg::ST_RDATA);
  wire in_wd = (state_r == sfd_pkg::ST_WDATA);
  wire in_wait = (state_r == sfd_pkg::ST_WAIT);
  // double-rate address also takes bits on the falling clock edge
  wire smp = (rise || (fall && info_r.ddr && in_addr)) &&
             (in_opc || in_addr || in_wd || in_wait);
  wire [2:0] w_cur = in_opc ? (quad_r ? `SFD_LANE_4 : `SFD_LANE_1) :
                     in_addr ? info_r.addr_w : info_r.data_w;
  wire [31:0] sh_new = shift_in(sh_r, io_s, w_cur);
  wire [5:0] cnt_new = phase_cnt_r + {3'h0, w_cur};
  wire [5:0] addr_need = enter_long_address_cmd ? `SFD_ADDR4_BITS
                                                : `SFD_ADDR3_BITS;
  wire [31:0] addr_mask = enter_long_address_cmd ? sh_new
                                                 : {8'h00, sh_new[23:0]};
  wire [4:0] dum_need = dummy_len({dummy_count_sel_hi,
                                   dummy_count_sel_lo});
  wire sfd_pkg::sfd_cmd_info_t dec = cmd_decode(sh_new[7:0], quad_r);
  wire addr_done = smp && in_addr && (cnt_new == addr_need);
  wire opc_done = smp && in_opc && (cnt_new == `SFD_OPC_BITS);
  wire dum_done = rise && (state_r == sfd_pkg::ST_DUMMY) &&
                  (dum_cnt_r + 5'h01 == dum_need);
  wire bnd = (in_wait || in_wd) && (phase_cnt_r[2:0] == 3'h0);
  wire commit = cs_rise && bnd;
  wire wbyte = smp && in_wd && (cnt_new[2:0] == 3'h0);
  wire is_op = (info_r.kind == sfd_pkg::CK_PROG && pcount_r != 9'h0) ||
               info_r.kind == sfd_pkg::CK_SE4K ||
               info_r.kind == sfd_pkg::CK_BE32K ||
               info_r.kind == sfd_pkg::CK_BE64K ||
               info_r.kind == sfd_pkg::CK_CHIP;
  // outputs move on the falling edge, and on both edges at double rate
  wire oev = in_rd && (fall || (rise && info_r.ddr));
  wire load = oev && (out_cnt_r == 4'h0);
  wire [7:0] out_word = load ? (fifo_valid ? fifo_data : `SFD_IDLE_BYTE)
                             : out_sh_r;
  wire [3:0] oe_mask = (info_r.data_w == `SFD_LANE_4) ? `SFD_OE_QUAD :
                       (info_r.data_w == `SFD_LANE_2) ? `SFD_OE_DUAL :
                                                        `SFD_OE_SINGLE;
  wire [3:0] out_bits = (info_r.data_w == `SFD_LANE_4) ? out_word[7:4] :
                        (info_r.data_w == `SFD_LANE_2) ?
                        {2'h0, out_word[7:6]} : {2'h0, out_word[7], 1'b0};
  wire [3:0] out_cnt_nxt = (load ? 4'h8 : out_cnt_r) - {1'b0, info_r.data_w};

  always_comb begin
    state_nxt = state_r;
    if (cs_n_s) begin
      state_nxt = sfd_pkg::ST_IDLE;
    end else if (cs_fall) begin
      state_nxt = sfd_pkg::ST_OPC;
    end else if (opc_done) begin
      if (dec.kind == sfd_pkg::CK_BAD) begin
        state_nxt = sfd_pkg::ST_IGNORE;
      end else if (dec.has_addr) begin
        state_nxt = sfd_pkg::ST_ADDR;
      end else begin
        state_nxt = sfd_pkg::ST_WAIT;
      end
    end else if (addr_done) begin
      if (info_r.kind == sfd_pkg::CK_READ) begin
        state_nxt = info_r.dummy ? sfd_pkg::ST_DUMMY : sfd_pkg::ST_RDATA;
      end else if (info_r.kind == sfd_pkg::CK_PROG) begin
        state_nxt = sfd_pkg::ST_WDATA;
      end else begin
        state_nxt = sfd_pkg::ST_WAIT;
      end
    end else if (dum_done) begin
      state_nxt = sfd_pkg::ST_RDATA;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_r <= 6'h10;
      sync2_r <= 6'h10;
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end else begin
      sync1_r <= {sclk_pin, cs_n_pin, io_in};
      sync2_r <= sync1_r;
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= sfd_pkg::ST_IDLE;
      info_r <= '0;
      sh_r <= '0;
      phase_cnt_r <= '0;
      dum_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      sh_r <= smp ? sh_new : sh_r;
      if (opc_done) begin
        info_r <= dec;
      end
      phase_cnt_r <= (state_nxt != state_r) ? 6'h00
                     : smp ? cnt_new : phase_cnt_r;
      dum_cnt_r <= (state_r != sfd_pkg::ST_DUMMY) ? 5'h00
                   : rise ? dum_cnt_r + 5'h01 : dum_cnt_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      quad_r <= 1'b0;
      addr_r <= '0;
      pcount_r <= '0;
      op_valid <= 1'b0;
      op_kind <= sfd_pkg::CK_BAD;
      op_addr <= '0;
      op_bytes <= '0;
      prog_byte_valid <= 1'b0;
      prog_byte <= '0;
    end else begin
      if (commit && info_r.kind == sfd_pkg::CK_ENQ) begin
        quad_r <= 1'b1;
      end else if (commit && info_r.kind == sfd_pkg::CK_EXQ) begin
        quad_r <= 1'b0;
      end
      addr_r <= addr_done ? addr_mask : cs_fall ? 32'h0 : addr_r;
      pcount_r <= cs_fall ? 9'h0 : (wbyte && pcount_r != `SFD_PAGE_BYTES)
                  ? pcount_r + 9'h1 : pcount_r;
      op_valid <= commit && is_op;
      op_kind <= (commit && is_op) ? info_r.kind : op_kind;
      op_addr <= (commit && is_op) ? addr_r : op_addr;
      op_bytes <= (commit && is_op) ? pcount_r : op_bytes;
      prog_byte_valid <= wbyte;
      prog_byte <= wbyte ? sh_new[7:0] : prog_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_start <= 1'b0;
      rd_addr <= '0;
      out_sh_r <= '0;
      out_cnt_r <= '0;
      io_out <= '0;
      io_oe <= '0;
    end else begin
      rd_start <= (state_nxt == sfd_pkg::ST_RDATA) && !in_rd;
      rd_addr <= addr_done ? addr_mask : rd_addr;
      out_sh_r <= oev ? out_word << info_r.data_w : out_sh_r;
      out_cnt_r <= !in_rd ? 4'h0 : oev ? out_cnt_nxt : out_cnt_r;
      io_out <= oev ? out_bits : io_out;
      io_oe <= (state_nxt == sfd_pkg::ST_RDATA) ? oe_mask : 4'h0;
    end
  end

  assign quad_mode = quad_r;
  assign rd_active = in_rd;

  // read-ahead buffer; the array stalls when it fills
  // held empty outside the data phase so no late byte leaks into a new read
  sfd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(core_clk),
    .rst(rst),
    .flush(cs_rise || !in_rd),
    .in_valid(arr_valid),
    .in_ready(arr_ready),
    .in_data(arr_data),
    .out_valid(fifo_valid),
    .out_ready(load),
    .out_data(fifo_data)
  );

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_enq_commit;
    in_wait && info_r.kind == sfd_pkg::CK_ENQ && bnd ##0 cs_rise;
  endsequence
  sequence s_exq_commit;
    in_wait && info_r.kind == sfd_pkg::CK_EXQ && bnd ##0 cs_rise;
  endsequence

  a_quad_enter: assert property (s_enq_commit |=> quad_r[*3])
    else $error("quad mode not entered");
  a_quad_exit: assert property (s_exq_commit |=> !quad_r[*3])
    else $error("quad mode not left");
  a_quad_lanes: assert property (quad_r && in_opc |-> w_cur == 3'h4)
    else $error("opcode not on four lanes in quad mode");
  a_ignore_hiz: assert property (state_r == sfd_pkg::ST_IGNORE |=>
    io_oe == 4'h0) else $error("outputs driven after bad opcode");
  a_mode_reject: assert property (opc_done && quad_r &&
    sh_new[7:0] == `SFD_OP_QUAD_OUT_READ |=> state_r == sfd_pkg::ST_IGNORE)
    else $error("single-lane command accepted in quad mode");
  a_addr_length: assert property (addr_done |->
    cnt_new == (enter_long_address_cmd ? 6'h20 : 6'h18))
    else $error("address phase length wrong");
  a_dummy_length: assert property ($rose(in_rd) && info_r.dummy |->
    $past(dum_cnt_r) + 5'h01 == $past(dum_need))
    else $error("dummy phase length wrong");
  a_op_boundary: assert property (op_valid |->
    $past(cs_rise) && $past(phase_cnt_r[2:0]) == 3'h0)
    else $error("operation issued off a byte boundary");
  a_out_on_fall: assert property (io_out != $past(io_out) |->
    $past(oev)) else $error("output moved without a clock edge");
endmodule // sfd_cmd_decoder

// *** rtl/sfd_fifo.sv ***
// synchronous fifo with valid/ready on both sides and a flush
module sfd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire empty = (wr_r == rd_r);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end

  // flush drops stale read-ahead when the frame ends
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_r + (AW+1)'(push);
      rd_r <= rd_r + (AW+1)'(pop);
    end
  end
endmodule // sfd_fifo

// *** rtl/sfd_map.svh ***
// opcode values, lane widths, dummy counts and phase lengths of the decoder
`ifndef SFD_MAP_SVH
`define SFD_MAP_SVH

`define SFD_OP_READ 8'h03
`define SFD_OP_FAST_READ 8'h0b
`define SFD_OP_DUAL_IO_READ 8'hbb
`define SFD_OP_DUAL_OUT_READ 8'h3b
`define SFD_OP_QUAD_IO_READ 8'heb
`define SFD_OP_QUAD_OUT_READ 8'h6b
`define SFD_OP_DDR1_READ 8'h0d
`define SFD_OP_DDR2_READ 8'hbd
`define SFD_OP_DDR4_READ 8'hed
`define SFD_OP_PAGE_PROG 8'h02
`define SFD_OP_QUAD_PROG 8'h38
`define SFD_OP_SECTOR_ERASE 8'h20
`define SFD_OP_HALF_BLOCK_ERASE 8'h52
`define SFD_OP_BLOCK_ERASE 8'hd8
`define SFD_OP_CHIP_ERASE_A 8'h60
`define SFD_OP_CHIP_ERASE_B 8'hc7
`define SFD_OP_ENTER_QUAD 8'h35
`define SFD_OP_EXIT_QUAD 8'hf5

`define SFD_LANE_1 3'h1
`define SFD_LANE_2 3'h2
`define SFD_LANE_4 3'h4

`define SFD_OPC_BITS 6'h08
`define SFD_ADDR3_BITS 6'h18
`define SFD_ADDR4_BITS 6'h20

`define SFD_DUMMY_SEL0 5'h08
`define SFD_DUMMY_SEL1 5'h06
`define SFD_DUMMY_SEL2 5'h08
`define SFD_DUMMY_SEL3 5'h0a

`define SFD_PAGE_BYTES 9'h100
`define SFD_IDLE_BYTE 8'hff

`define SFD_OE_SINGLE 4'h2
`define SFD_OE_DUAL 4'h3
`define SFD_OE_QUAD 4'hf

`endif

// *** rtl/sfd_pkg.sv ***
// types shared by the serial flash command decoder
package sfd_pkg;
  typedef enum logic [3:0] {
    CK_BAD, CK_READ, CK_PROG, CK_SE4K, CK_BE32K, CK_BE64K, CK_CHIP,
    CK_ENQ, CK_EXQ
  } sfd_cmd_kind_t;

  typedef struct packed {
    sfd_cmd_kind_t kind;
    logic has_addr;
    logic [2:0] addr_w;
    logic [2:0] data_w;
    logic dummy;
    logic ddr;
  } sfd_cmd_info_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC = 3'b001,
    ST_ADDR = 3'b011,
    ST_DUMMY = 3'b010,
    ST_RDATA = 3'b110,
    ST_WDATA = 3'b111,
    ST_WAIT = 3'b101,
    ST_IGNORE = 3'b100
  } sfd_state_t;
endpackage

// *** testbench/sfd_cmd_decoder_tb.sv ***
// self-checking bench of the serial flash command decoder
module sfd_cmd_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst, sclk_pin, cs_n_pin, long_a, dsl, dsh, qm;
  logic [3:0] io_in, io_out, io_oe;
  logic quad_mode, rd_start, rd_active, arr_valid, arr_ready;
  logic prog_byte_valid, op_valid, saw_full;
  logic [31:0] rd_addr, op_addr, ra, la;
  logic [7:0] arr_data, prog_byte, rx, r0, r1, r2;
  logic [8:0] op_bytes, lb;
  sfd_pkg::sfd_cmd_kind_t op_kind, lk;
  int err_count, checks, op_cnt, rs_cnt, n0, i;
  logic [7:0] pb[$];
  logic [7:0] eop[5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
  sfd_pkg::sfd_cmd_kind_t ekd[5] = '{sfd_pkg::CK_SE4K,
    sfd_pkg::CK_BE32K, sfd_pkg::CK_BE64K, sfd_pkg::CK_CHIP,
    sfd_pkg::CK_CHIP};
  logic [7:0] rop[6] = '{8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b};
  int raw[6] = '{1, 1, 2, 1, 4, 1};
  int rdw[6] = '{1, 1, 2, 2, 4, 4};
  logic [3:0] roe[6] = '{4'h2, 4'h2, 4'h3, 4'h3, 4'hf, 4'hf};

  sfd_cmd_decoder dut_u (.core_clk(core_clk), .rst(rst),
    .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .enter_long_address_cmd(long_a),
    .dummy_count_sel_lo(dsl), .dummy_count_sel_hi(dsh),
    .quad_mode(quad_mode), .rd_start(rd_start), .rd_addr(rd_addr),
    .rd_active(rd_active), .arr_valid(arr_valid),
    .arr_ready(arr_ready), .arr_data(arr_data),
    .prog_byte_valid(prog_byte_valid), .prog_byte(prog_byte),
    .op_valid(op_valid), .op_kind(op_kind), .op_addr(op_addr),
    .op_bytes(op_bytes));
  sfd_host_model host_u (.core_clk(core_clk), .sclk_pin(sclk_pin),
    .cs_n_pin(cs_n_pin), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // array side offers bytes only in a read, so the fifo fills and stalls
  always @(posedge core_clk) begin
    arr_valid <= (rd_active === 1'b1);
    if (arr_valid && arr_ready === 1'b1) arr_data <= arr_data + 8'h01;
    if (rd_active === 1'b1 && arr_ready === 1'b0) saw_full <= 1'b1;
    if (op_valid === 1'b1) begin
      op_cnt <= op_cnt + 1;
      lk <= op_kind;
      la <= op_addr;
      lb <= op_bytes;
    end
    if (prog_byte_valid === 1'b1) pb.push_back(prog_byte);
    if (rd_start === 1'b1) begin
      rs_cnt <= rs_cnt + 1;
      ra <= rd_addr;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // eb: trailing bits that break the byte boundary
  task automatic cmd(input logic [7:0] op, input int nab, aw, nd, eb,
      input logic [31:0] a, input bit lg);
    int k;
    host_u.frame_begin();
    host_u.xfer(op, qm ? 4 : 1, 8, 1, rx);
    for (k = nab - 1; k >= 0; k--) host_u.xfer(a[8*k +: 8], aw, 8, 1, rx);
    for (k = 0; k < nd; k++) host_u.xfer(8'h40 + 8'(k), aw, 8, 1, rx);
    if (eb > 0) host_u.xfer(8'hc3, aw, eb, 1, rx);
    host_u.frame_end(lg);
  endtask
  task automatic rd(input logic [7:0] op, input int aw, dw, nd,
      input logic [3:0] oe, input logic [31:0] a);
    int n;
    int k;
    n = rs_cnt;
    host_u.frame_begin();
    host_u.xfer(op, qm ? 4 : 1, 8, 1, rx);
    for (k = 2; k >= 0; k--) host_u.xfer(a[8*k +: 8], aw, 8, 1, rx);
    host_u.clocks(nd);
    host_u.xfer(8'h00, dw, 8, 0, r0);
    chk("io_oe", oe, io_oe);
    #400;
    host_u.xfer(8'h00, dw, 8, 0, r1);
    host_u.xfer(8'h00, dw, 8, 0, r2);
    host_u.frame_end(0);
    chk("rd_start", n + (oe != 4'h0), rs_cnt);
    if (oe != 4'h0) begin
      chk("rd_addr", a, ra);
      chk("stream", 8'(r1 + 8'h01), r2);
    end
  endtask
  // double-rate reads: zero address, entry into the data phase checked
  task automatic ddr(input logic [7:0] op, input int w,
      input logic [3:0] oe);
    int n;
    n = rs_cnt;
    host_u.frame_begin();
    host_u.xfer(op, qm ? 4 : 1, 8, 1, rx);
    repeat (6) host_u.xfer(8'h00, w, 8, 1, rx);
    chk("io_oe", oe, io_oe);
    host_u.frame_end(0);
    chk("rd_start", n + 1, rs_cnt);
    chk("rd_addr", 0, ra);
  endtask
  function automatic int dum(input int s);
    return (s == 3) ? 10 : (s == 1) ? 6 : 8;
  endfunction

  initial begin
    rst = 1'b1;
    long_a = 1'b0;
    dsl = 1'b0;
    dsh = 1'b0;
    qm = 1'b0;
    arr_valid = 1'b0;
    arr_data = 8'h00;
    saw_full = 1'b0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("quad_mode", 0, quad_mode);
    chk("io_oe", 0, io_oe);
    for (i = 0; i < 5; i++) begin
      n0 = op_cnt;
      cmd(eop[i], (i < 3) ? 3 : 0, 1, 0, 0, 32'h0012_3450 + i, 0);
      chk("op_cnt", n0 + 1, op_cnt);
      chk("op_kind", ekd[i], lk);
      if (i < 3) chk("op_addr", 32'h0012_3450 + i, la);
    end
    n0 = op_cnt;
    cmd(8'h20, 3, 1, 0, 4, 32'h0000_1000, 0);
    chk("op_cnt", n0, op_cnt);
    pb.delete();
    cmd(8'h02, 3, 1, 3, 0, 32'h0000_0100, 0);
    chk("op_kind", sfd_pkg::CK_PROG, lk);
    chk("op_bytes", 3, lb);
    chk("prog_cnt", 3, pb.size());
    chk("prog_byte", 8'h42, pb[2]);
    @(posedge core_clk);
    long_a <= 1'b1;
    cmd(8'h38, 4, 4, 1, 0, 32'h8765_4321, 0);
    chk("op_addr", 32'h8765_4321, la);
    chk("op_bytes", 1, lb);
    @(posedge core_clk);
    long_a <= 1'b0;
    for (i = 0; i < 6; i++) begin
      rd(rop[i], raw[i], rdw[i], (i == 0) ? 0 : 8, roe[i],
        32'h00a0_0000 + i);
    end
    for (i = 1; i < 4; i++) begin
      @(posedge core_clk);
      {dsh, dsl} <= 2'(i);
      rd(8'h0b, 1, 1, dum(i), 4'h2, 32'h0000_0777);
    end
    @(posedge core_clk);
    {dsh, dsl} <= 2'h0;
    rd(8'ha5, 1, 1, 8, 4'h0, 0);
    ddr(8'h0d, 1, 4'h2);
    ddr(8'hbd, 2, 4'h3);
    ddr(8'hed, 4, 4'hf);
    cmd(8'h35, 0, 1, 0, 0, 0, 1);
    chk("quad_mode", 1, quad_mode);
    qm = 1'b1;
    rd(8'h6b, 1, 4, 8, 4'h0, 0);
    rd(8'hbd, 2, 2, 8, 4'h0, 0);
    rd(8'heb, 4, 4, 8, 4'hf, 32'h0055_6677);
    ddr(8'hed, 4, 4'hf);
    n0 = op_cnt;
    cmd(8'h02, 3, 4, 2, 0, 32'h0033_4400, 0);
    chk("op_cnt", n0 + 1, op_cnt);
    chk("op_bytes", 2, lb);
    chk("op_addr", 32'h0033_4400, la);
    cmd(8'hf5, 0, 4, 0, 0, 0, 1);
    qm = 1'b0;
    chk("quad_mode", 0, quad_mode);
    rd(8'h03, 1, 1, 0, 4'h2, 32'h0000_0042);
    chk("fifo_full", 1, saw_full);
    end_of_test();
  end
  // the whole sequence needs about 150 us
  initial begin
    #600us;
    err_count++;
    end_of_test();
  end
endmodule // sfd_cmd_decoder_tb

// *** testbench/sfd_host_model.sv ***
// host controller model: serial clock, select and lane drive
module sfd_host_model #(
  parameter real HALF_NS = 62.5,
  parameter int LONG_DESEL_NS = 800
) (
  // core clock for frame phase
  input wire logic core_clk,
  // pins toward the decoder
  output logic sclk_pin,
  output logic cs_n_pin,
  output logic [3:0] io_in,
  // decoder lane drive
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] h_oe;
  logic [3:0] h_do;
  logic [3:0] junk;
  // undriven lanes move every cycle so a stale level never passes
  assign io_in = (h_oe & h_do) | (~h_oe & io_oe & io_out) |
    (~h_oe & ~io_oe & junk);
  initial begin
    sclk_pin = 1'b0;
    cs_n_pin = 1'b1;
    h_oe = 4'h0;
    h_do = 4'h0;
    junk = 4'h5;
    forever #10 junk = ~junk;
  end
  // 3 ns offset keeps pin edges off the core clock edges
  task automatic frame_begin();
    @(posedge core_clk);
    #3;
    cs_n_pin = 1'b0;
    #(HALF_NS);
  endtask
  task automatic xfer(input logic [7:0] tx, input int w, input int nb,
      input bit drv, output logic [7:0] rx);
    logic [3:0] m;
    logic [3:0] smp;
    logic [7:0] s;
    int i;
    m = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : 4'h1;
    rx = 8'h00;
    for (i = 0; i < nb; i += w) begin
      s = tx << i;
      h_oe = drv ? m : 4'h0;
      h_do = 4'(s >> (8 - w));
      #(HALF_NS);
      smp = (w == 1) ? {3'h0, io_in[1]} : (io_in & m);
      rx = (rx << w) | {4'h0, smp};
      sclk_pin = 1'b1;
      #(HALF_NS);
      sclk_pin = 1'b0;
    end
    h_oe = 4'h0;
  endtask
  task automatic clocks(input int n);
    repeat (n) begin
      #(HALF_NS);
      sclk_pin = 1'b1;
      #(HALF_NS);
      sclk_pin = 1'b0;
    end
  endtask
  // select rises half a clock after the last clock fall; the byte boundary is left to the caller
  task automatic frame_end(input bit long_gap);
    #(HALF_NS);
    cs_n_pin = 1'b1;
    #(long_gap ? LONG_DESEL_NS : 200);
  endtask
endmodule // sfd_host_model
